//--- core/hdc_pkg.sv
// Purpose: Shared constants for the haptic drive configuration bank
// Assumes: 40 MHz ref_clk, AXI4-Lite register access with 32-bit data
// Notes:   Byte address of a register is four times its index
package hdc_pkg;
  // ==========================================================
  // Register indices
  localparam logic [5:0] IDX_DF_HIGH    = 6'h0F;
  localparam logic [5:0] IDX_DF_LOW     = 6'h10;
  localparam logic [5:0] IDX_IMP_UPPER  = 6'h11;
  localparam logic [5:0] IDX_IMP_LOWER  = 6'h12;
  localparam logic [5:0] IDX_MAIN_CFG   = 6'h13;
  localparam logic [5:0] IDX_MEMBRK_CFG = 6'h14;
  localparam logic [5:0] IDX_HEAD_CFG   = 6'h15;
  localparam logic [5:0] IDX_CALUPD_CFG = 6'h16;
  localparam logic [5:0] IDX_LOOP_CFG   = 6'h17;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h18;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h19;
  // ==========================================================
  // Reset values and writable-bit masks
  localparam logic [7:0] RST_DF_HIGH    = 8'h01;
  localparam logic [7:0] RST_DF_LOW     = 8'h0D;
  localparam logic [7:0] RST_MAIN_CFG   = 8'h1E;
  localparam logic [7:0] RST_MEMBRK_CFG = 8'h01;
  localparam logic [7:0] RST_HEAD_CFG   = 8'h03;
  localparam logic [7:0] RST_CALUPD_CFG = 8'h40;
  localparam logic [7:0] RST_LOOP_CFG   = 8'h81;
  localparam logic [7:0] WM_MAIN_CFG    = 8'hBF;
  localparam logic [7:0] WM_MEMBRK_CFG  = 8'h1F;
  localparam logic [7:0] WM_HEAD_CFG    = 8'h0F;
  localparam logic [7:0] WM_CALUPD_CFG  = 8'hC0;
  // ==========================================================
  // Field positions
  localparam int B_EMBED    = 7;
  localparam int B_ERM      = 5;
  localparam int B_LOOP     = 4;
  localparam int B_TRACK    = 3;
  localparam int B_ACCEL    = 2;
  localparam int B_BRAKE    = 1;
  localparam int B_AMP      = 0;
  localparam int B_SIGNED   = 4;
  localparam int B_HOLD     = 7;
  localparam int B_PLAYHOLD = 6;
  localparam int LOCK_LSB   = 2;
  localparam int ST_CLAMP   = 0;
  localparam int ST_BEMF    = 1;
  // ==========================================================
  // Thresholds: voltage in 62.5 mV units, back-EMF in 0.1 mV units
  localparam logic [15:0] HEADROOM_STEP = 16'h0003;
  localparam logic [15:0] BEMF_THR1     = 16'h0031;
  localparam logic [15:0] BEMF_THR2     = 16'h0117;
  localparam logic [15:0] BEMF_THR3     = 16'h01F3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

//--- core/hdc_regs.sv
// Purpose: Haptic drive configuration and calibration register bank
// Assumes: AXI4-Lite slave, one write and one read under way at a time
// Notes:   Registers sit in the low byte of each word
// Operation
// - Drive factor is 16 bits; low byte register resets to 0x0D.
// - High byte sits one index lower, resets to 0x01, forms upper half.
// - Impedance reads as 8-bit upper (x4) and 2-bit lower, 62.5 mohm units.
// - Embedded bit 0 keeps faults latched; 1 clears them automatically.
// - Actuator type 0 selects linear resonant, 1 rotating mass; resets 0.
// - Loop computation bit 1 enables internal loops; resets to 1.
// - Frequency tracking bit resets 1 and is ignored in rotating mass mode.
// - Acceleration enable bit turns closed-loop acceleration on; resets 1.
// - Braking enable bit turns active braking on; resets to 1.
// - Amplitude loop enable bit turns amplitude control on; resets 0.
// - PWM brake threshold 0 disables; each code adds 6.66 percent.
// - Target above supply minus headroom is clamped and raises an event.
// - Drive factor hold bit stops every automatic factor update.
// - Playback hold bit stops automatic updates during playback; resets 1.
// - Lock when tracking error is below four times the limit field.
// - Back-EMF below selected threshold faults; code 0 disables.
//
// The AXI4-Lite interface to the registers is this design's own decision.
module hdc_regs #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // Calibration engine
  input  wire logic              imp_valid,
  input  wire logic [9:0]        imp_value,
  input  wire logic              df_upd_valid,
  input  wire logic [15:0]       df_upd_value,
  input  wire logic              playback_active,
  // Drive loop measurements
  input  wire logic [15:0]       target_volt,
  input  wire logic [15:0]       supply_volt,
  input  wire logic [7:0]        track_error,
  input  wire logic              bemf_valid,
  input  wire logic [15:0]       bemf_level,
  input  wire logic              pwm_mode,
  input  wire logic [3:0]        pwm_level,
  // Configuration outputs
  output logic [15:0]            drive_factor,
  output logic                   embedded_mode,
  output logic                   actuator_erm,
  output logic                   loop_computation_enable,
  output logic                   freq_tracking_active,
  output logic                   accel_enable,
  output logic                   braking_enable,
  output logic                   amplitude_loop_enable,
  output logic                   memory_signed,
  // Loop results
  output logic [15:0]            drive_volt,
  output logic                   drive_clamped_event,
  output logic                   freq_locked,
  output logic                   pwm_full_brake,
  output logic                   bemf_fault,
  output logic                   irq
);
  // ==========================================================
  // State
  typedef struct packed {
    logic        awrdy;
    logic        wrdy;
    logic        aw_ok;
    logic        w_ok;
    logic [5:0]  widx;
    logic [7:0]  wdat;
    logic        wstb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic [7:0]  dfh;
    logic [7:0]  dfl;
    logic [7:0]  imph;
    logic [1:0]  impl;
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  cfg3;
    logic [7:0]  cfg4;
    logic [7:0]  icfg;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic        irq;
    logic        trk;
    logic [15:0] vout;
    logic        clamped;
    logic        locked;
    logic        brake;
    logic        bflt;
  } hdc_state_t;

  hdc_state_t st_r;
  hdc_state_t st_nxt;

  logic        wr_go;
  logic [15:0] margin;
  logic [15:0] v_limit;
  logic        clamp_now;
  logic [15:0] bemf_thr;
  logic        bemf_now;
  logic [1:0]  ev;

  function automatic logic idx_ok(input logic [5:0] i);
    idx_ok = (i >= hdc_pkg::IDX_DF_HIGH) && (i <= hdc_pkg::IDX_IRQ_MASK);
  endfunction

  function automatic logic [7:0] rd_mux(input hdc_state_t s, input logic [5:0] i);
    unique case (i)
      hdc_pkg::IDX_DF_HIGH:    rd_mux = s.dfh;
      hdc_pkg::IDX_DF_LOW:     rd_mux = s.dfl;
      hdc_pkg::IDX_IMP_UPPER:  rd_mux = s.imph;
      hdc_pkg::IDX_IMP_LOWER:  rd_mux = {6'h00, s.impl};
      hdc_pkg::IDX_MAIN_CFG:   rd_mux = s.cfg1;
      hdc_pkg::IDX_MEMBRK_CFG: rd_mux = s.cfg2;
      hdc_pkg::IDX_HEAD_CFG:   rd_mux = s.cfg3;
      hdc_pkg::IDX_CALUPD_CFG: rd_mux = s.cfg4;
      hdc_pkg::IDX_LOOP_CFG:   rd_mux = s.icfg;
      hdc_pkg::IDX_IRQ_STATUS: rd_mux = {6'h00, s.sts};
      hdc_pkg::IDX_IRQ_MASK:   rd_mux = {6'h00, s.msk};
      default:                 rd_mux = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Loop conditions
  always_comb begin
    margin  = 16'(st_r.cfg3[3:0] * hdc_pkg::HEADROOM_STEP);
    v_limit = (supply_volt > margin) ? 16'(supply_volt - margin) : 16'h0000;
    clamp_now = target_volt > v_limit;
    unique case (st_r.icfg[1:0])
      2'h1:    bemf_thr = hdc_pkg::BEMF_THR1;
      2'h2:    bemf_thr = hdc_pkg::BEMF_THR2;
      2'h3:    bemf_thr = hdc_pkg::BEMF_THR3;
      default: bemf_thr = 16'h0000;
    endcase
    bemf_now = bemf_valid && (bemf_level < bemf_thr);
    ev = {bemf_now, clamp_now};
    wr_go = st_r.aw_ok && st_r.w_ok && !st_r.bvalid;
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    // Write address and data are taken independently
    if (s_awvalid && st_r.awrdy) begin
      st_nxt.aw_ok = 1'b1;
      st_nxt.widx  = s_awaddr[7:2];
    end
    if (s_wvalid && st_r.wrdy) begin
      st_nxt.w_ok = 1'b1;
      st_nxt.wdat = s_wdata[7:0];
      st_nxt.wstb = s_wstrb[0];
    end
    if (s_bvalid && s_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Hardware updates of the drive factor and the impedance
    if (df_upd_valid && !st_r.cfg4[hdc_pkg::B_HOLD]
        && !(playback_active && st_r.cfg4[hdc_pkg::B_PLAYHOLD])) begin
      {st_nxt.dfh, st_nxt.dfl} = df_upd_value;
    end
    if (imp_valid) begin
      {st_nxt.imph, st_nxt.impl} = imp_value;
    end
    // Fault flags: embedded mode drops a flag once its cause is gone
    if (st_r.cfg1[hdc_pkg::B_EMBED]) begin
      st_nxt.sts = st_r.sts & ev;
    end
    if (wr_go) begin
      st_nxt.aw_ok  = 1'b0;
      st_nxt.w_ok   = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = idx_ok(st_r.widx) ? hdc_pkg::RESP_OKAY : hdc_pkg::RESP_SLVERR;
      if (st_r.wstb) begin
        unique case (st_r.widx)
          hdc_pkg::IDX_DF_HIGH:    st_nxt.dfh = st_r.wdat;
          hdc_pkg::IDX_DF_LOW:     st_nxt.dfl = st_r.wdat;
          hdc_pkg::IDX_MAIN_CFG:   st_nxt.cfg1 = st_r.wdat & hdc_pkg::WM_MAIN_CFG;
          hdc_pkg::IDX_MEMBRK_CFG: st_nxt.cfg2 = st_r.wdat & hdc_pkg::WM_MEMBRK_CFG;
          hdc_pkg::IDX_HEAD_CFG:   st_nxt.cfg3 = st_r.wdat & hdc_pkg::WM_HEAD_CFG;
          hdc_pkg::IDX_CALUPD_CFG: st_nxt.cfg4 = st_r.wdat & hdc_pkg::WM_CALUPD_CFG;
          hdc_pkg::IDX_LOOP_CFG:   st_nxt.icfg = st_r.wdat;
          hdc_pkg::IDX_IRQ_STATUS: st_nxt.sts = st_nxt.sts & ~st_r.wdat[1:0];
          hdc_pkg::IDX_IRQ_MASK:   st_nxt.msk = st_r.wdat[1:0];
          default:                 st_nxt.sts = st_nxt.sts;
        endcase
      end
    end
    // New events win over a clear in the same cycle
    st_nxt.sts   = st_nxt.sts | ev;
    st_nxt.irq   = |(st_nxt.sts & st_nxt.msk);
    st_nxt.awrdy = !st_nxt.aw_ok && !st_nxt.bvalid;
    st_nxt.wrdy  = !st_nxt.w_ok && !st_nxt.bvalid;
    // Read path
    if (s_rvalid && s_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_arvalid && st_r.arrdy) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_mux(st_r, s_araddr[7:2]);
      st_nxt.rresp  = idx_ok(s_araddr[7:2]) ? hdc_pkg::RESP_OKAY : hdc_pkg::RESP_SLVERR;
    end
    st_nxt.arrdy = !st_nxt.rvalid;
    // Loop results
    st_nxt.trk     = st_r.cfg1[hdc_pkg::B_TRACK] && !st_r.cfg1[hdc_pkg::B_ERM];
    st_nxt.vout    = clamp_now ? v_limit : target_volt;
    st_nxt.clamped = clamp_now;
    st_nxt.locked  = track_error < {st_r.icfg[7:hdc_pkg::LOCK_LSB], 2'h0};
    st_nxt.brake   = pwm_mode && (st_r.cfg2[3:0] != 4'h0)
                     && (pwm_level < st_r.cfg2[3:0]);
    st_nxt.bflt    = bemf_now;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r       <= '0;
      st_r.awrdy <= 1'b1;
      st_r.wrdy  <= 1'b1;
      st_r.arrdy <= 1'b1;
      st_r.dfh   <= hdc_pkg::RST_DF_HIGH;
      st_r.dfl   <= hdc_pkg::RST_DF_LOW;
      st_r.cfg1  <= hdc_pkg::RST_MAIN_CFG;
      st_r.cfg2  <= hdc_pkg::RST_MEMBRK_CFG;
      st_r.cfg3  <= hdc_pkg::RST_HEAD_CFG;
      st_r.cfg4  <= hdc_pkg::RST_CALUPD_CFG;
      st_r.icfg  <= hdc_pkg::RST_LOOP_CFG;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign s_awready               = st_r.awrdy;
  assign s_wready                = st_r.wrdy;
  assign s_bvalid                = st_r.bvalid;
  assign s_bresp                 = st_r.bresp;
  assign s_arready               = st_r.arrdy;
  assign s_rvalid                = st_r.rvalid;
  assign s_rresp                 = st_r.rresp;
  assign s_rdata                 = {24'h00_0000, st_r.rdata};
  assign drive_factor            = {st_r.dfh, st_r.dfl};
  assign embedded_mode           = st_r.cfg1[hdc_pkg::B_EMBED];
  assign actuator_erm            = st_r.cfg1[hdc_pkg::B_ERM];
  assign loop_computation_enable = st_r.cfg1[hdc_pkg::B_LOOP];
  assign freq_tracking_active    = st_r.trk;
  assign accel_enable            = st_r.cfg1[hdc_pkg::B_ACCEL];
  assign braking_enable          = st_r.cfg1[hdc_pkg::B_BRAKE];
  assign amplitude_loop_enable   = st_r.cfg1[hdc_pkg::B_AMP];
  assign memory_signed           = st_r.cfg2[hdc_pkg::B_SIGNED];
  assign drive_volt              = st_r.vout;
  assign drive_clamped_event     = st_r.clamped;
  assign freq_locked             = st_r.locked;
  assign pwm_full_brake          = st_r.brake;
  assign bemf_fault              = st_r.bflt;
  assign irq                     = st_r.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence s_resp;
    ##[1:2] s_bvalid;
  endsequence

  property p_wr_resp;
    s_wr_taken |-> s_resp;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");

  property p_imp_ro;
    !imp_valid |=> $stable({st_r.imph, st_r.impl});
  endproperty
  a_imp_ro: assert property (p_imp_ro) else $error("impedance changed");

  property p_hold;
    st_r.cfg4[hdc_pkg::B_HOLD] && !wr_go |=> $stable(drive_factor);
  endproperty
  a_hold: assert property (p_hold) else $error("factor moved on hold");

  property p_play_hold;
    playback_active && st_r.cfg4[hdc_pkg::B_PLAYHOLD] && !wr_go |=> $stable(drive_factor);
  endproperty
  a_play_hold: assert property (p_play_hold) else $error("factor moved in play");

  property p_upd;
    nrst && df_upd_valid && !st_r.cfg4[hdc_pkg::B_HOLD] && !playback_active && !wr_go
      |=> drive_factor == $past(df_upd_value);
  endproperty
  a_upd: assert property (p_upd) else $error("factor update lost");

  property p_lock;
    nrst |=> freq_locked == ($past(track_error) < {$past(st_r.icfg[7:2]), 2'h0});
  endproperty
  a_lock: assert property (p_lock) else $error("lock flag wrong");

  property p_clamp;
    nrst && clamp_now |=> drive_clamped_event && drive_volt == $past(v_limit) && st_r.sts[0];
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp missing");

  property p_trk;
    actuator_erm |=> !freq_tracking_active;
  endproperty
  a_trk: assert property (p_trk) else $error("tracking on in erm");

  property p_bemf;
    st_r.icfg[1:0] == 2'h0 |=> !bemf_fault;
  endproperty
  a_bemf: assert property (p_bemf) else $error("bemf fault disabled");

  property p_latch;
    !embedded_mode && st_r.sts[1] && !wr_go |=> st_r.sts[1];
  endproperty
  a_latch: assert property (p_latch) else $error("fault not latched");

  property p_irq;
    ##1 irq == |(st_r.sts & st_r.msk);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  sequence s_rd_taken;
    nrst && s_arvalid && s_arready;
  endsequence

  property p_rd_resp;
    s_rd_taken |=> s_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");

  property p_brake_off;
    st_r.cfg2[3:0] == 4'h0 |=> !pwm_full_brake;
  endproperty
  a_brake_off: assert property (p_brake_off) else $error("brake with threshold off");

  property p_bemf_set;
    nrst && bemf_valid && bemf_level < hdc_pkg::BEMF_THR1 && st_r.icfg[1:0] != 2'h0
      |=> bemf_fault && st_r.sts[hdc_pkg::ST_BEMF];
  endproperty
  a_bemf_set: assert property (p_bemf_set) else $error("bemf fault missing");

  property p_embed_clr;
    embedded_mode && !clamp_now && !bemf_now |=> st_r.sts == 2'h0;
  endproperty
  a_embed_clr: assert property (p_embed_clr) else $error("fault not cleared");
endmodule

//--- tb/haptic_drive_config_regs_tb_top.sv
// Purpose: Self-checking bench for the haptic drive configuration bank
// Assumes: 40 MHz ref_clk, bench acts as AXI4-Lite master
// Notes:   Bus answers are noted in queues and checked by a monitor
module haptic_drive_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic        ref_clk, nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic [7:0]  s_awaddr, s_araddr, track_error;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb, pwm_level;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  logic        imp_valid, df_upd_valid, playback_active, bemf_valid, pwm_mode;
  logic [9:0]  imp_value;
  logic [15:0] df_upd_value, target_volt, supply_volt, bemf_level, drive_factor, drive_volt;
  logic        embedded_mode, actuator_erm, loop_computation_enable, freq_tracking_active;
  logic        accel_enable, braking_enable, amplitude_loop_enable, memory_signed;
  logic        drive_clamped_event, freq_locked, pwm_full_brake, bemf_fault, irq;
  logic [33:0] bq[$];
  logic [33:0] rq[$];
  logic [7:0]  v[0:8];
  int          fails, num_checks, cyc;
  logic [7:0]  rv[0:10] = '{8'h01, 8'h0D, 8'h00, 8'h00, 8'h1E, 8'h01, 8'h03, 8'h40, 8'h81,
                            8'h00, 8'h00};
  logic [7:0]  wm[0:8] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'hBF, 8'h1F, 8'h0F, 8'hC0, 8'hFF};

  hdc_regs dut (.*);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Checking
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (s_bvalid && s_bready) chk("bresp", 34'(s_bresp), bq.pop_front());
    if (s_rvalid && s_rready) chk("rdata", {s_rresp, s_rdata}, rq.pop_front());
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  // ==========================================================
  // Drivers
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] rsp);
    bit aw_ok = 0;
    bit w_ok = 0;
    @(posedge ref_clk);
    bq.push_back(34'(rsp));
    s_awaddr <= {idx, 2'b00};
    s_wdata <= {24'($urandom()), d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (!aw_ok && s_awready) begin
        aw_ok = 1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready) begin
        w_ok = 1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!s_bvalid);
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] rsp);
    @(posedge ref_clk);
    rq.push_back({rsp, 24'h00_0000, d});
    s_araddr <= {idx, 2'b00};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_rvalid);
    s_rready <= 1'b0;
  endtask

  task automatic pulse(input logic imp, input logic [15:0] val);
    @(posedge ref_clk);
    imp_value <= val[9:0];
    df_upd_value <= val;
    imp_valid <= imp;
    df_upd_valid <= !imp;
    @(posedge ref_clk);
    imp_valid <= 1'b0;
    df_upd_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic drv(input logic [15:0] t, input logic [15:0] s, input logic [7:0] te,
                     input logic [15:0] bl, input logic [3:0] pl);
    @(posedge ref_clk);
    target_volt <= t;
    supply_volt <= s;
    track_error <= te;
    bemf_level <= bl;
    pwm_level <= pl;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
  endtask
  // ==========================================================
  // Tests
  initial begin
    {nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, imp_valid} = '0;
    {df_upd_valid, playback_active, bemf_valid, pwm_mode, pwm_level} = '0;
    {s_awaddr, s_araddr, s_wdata, imp_value, df_upd_value, track_error} = '0;
    {target_volt, supply_volt, bemf_level} = '0;
    s_wstrb = 4'hF;
    void'($urandom(32'h0000_b3a9));
    do_reset();
    for (int i = 0; i < 11; i++) begin
      rd(6'h0F + 6'(i), rv[i], 2'h0);
    end
    chk("drive_factor", 34'(drive_factor), 34'h0_010D);
    $display("test reset_values done");
    repeat (4) begin
      for (int i = 0; i < 9; i++) begin
        v[i] = 8'($urandom());
        if (i == 5) v[5][4] = ~v[4][2];
        wr(6'h0F + 6'(i), v[i], 2'h0);
      end
      for (int i = 0; i < 9; i++) rd(6'h0F + 6'(i), v[i] & wm[i], 2'h0);
      chk("drive_factor", 34'(drive_factor), 34'({v[0], v[1]}));
      chk("config", 34'({embedded_mode, actuator_erm, loop_computation_enable,
          freq_tracking_active, accel_enable, braking_enable, amplitude_loop_enable,
          memory_signed}), 34'({v[4][7], v[4][5:4], v[4][3] & ~v[4][5], v[4][2:0],
          v[5][4]}));
    end
    wr(6'h20, 8'h5A, 2'h2);
    rd(6'h20, 8'h00, 2'h2);
    s_wstrb <= 4'hE;
    wr(hdc_pkg::IDX_DF_LOW, ~v[1], 2'h0);
    s_wstrb <= 4'hF;
    rd(hdc_pkg::IDX_DF_LOW, v[1], 2'h0);
    $display("test register_access done");
    do_reset();
    pulse(1'b1, 16'h02B7);
    wr(hdc_pkg::IDX_IMP_UPPER, 8'h55, 2'h0);
    rd(hdc_pkg::IDX_IMP_UPPER, 8'hAD, 2'h0);
    rd(hdc_pkg::IDX_IMP_LOWER, 8'h03, 2'h0);
    pulse(1'b0, 16'hABCD);
    chk("drive_factor", 34'(drive_factor), 34'h0_ABCD);
    playback_active <= 1'b1;
    pulse(1'b0, 16'h1234);
    chk("drive_factor", 34'(drive_factor), 34'h0_ABCD);
    wr(hdc_pkg::IDX_CALUPD_CFG, 8'h00, 2'h0);
    pulse(1'b0, 16'h1234);
    rd(hdc_pkg::IDX_DF_HIGH, 8'h12, 2'h0);
    wr(hdc_pkg::IDX_CALUPD_CFG, 8'h80, 2'h0);
    playback_active <= 1'b0;
    pulse(1'b0, 16'h5678);
    chk("drive_factor", 34'(drive_factor), 34'h0_1234);
    $display("test calibration done");
    drv(16'h005F, 16'h0064, 8'hFF, 16'hFFFF, 4'hF);
    chk("clamp", {drive_clamped_event, irq, drive_volt}, 34'h2_005B);
    rd(hdc_pkg::IDX_IRQ_STATUS, 8'h01, 2'h0);
    wr(hdc_pkg::IDX_IRQ_MASK, 8'h01, 2'h0);
    drv(16'h0032, 16'h0064, 8'hFF, 16'hFFFF, 4'hF);
    chk("latched", {drive_clamped_event, irq, drive_volt}, 34'h1_0032);
    wr(hdc_pkg::IDX_IRQ_STATUS, 8'h01, 2'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq", 34'(irq), 34'h0);
    wr(hdc_pkg::IDX_MAIN_CFG, 8'h9E, 2'h0);
    drv(16'h005F, 16'h0064, 8'hFF, 16'hFFFF, 4'hF);
    chk("irq", 34'(irq), 34'h1);
    drv(16'h0032, 16'h0064, 8'hFF, 16'hFFFF, 4'hF);
    chk("irq", 34'(irq), 34'h0);
    wr(hdc_pkg::IDX_HEAD_CFG, 8'h0F, 2'h0);
    drv(16'h003C, 16'h0064, 8'hFF, 16'hFFFF, 4'hF);
    chk("clamp", {drive_clamped_event, irq, drive_volt}, 34'h3_0037);
    wr(hdc_pkg::IDX_HEAD_CFG, 8'h00, 2'h0);
    drv(16'h0064, 16'h0064, 8'hFF, 16'hFFFF, 4'hF);
    chk("clamp", {drive_clamped_event, irq, drive_volt}, 34'h0_0064);
    $display("test clamp done");
    bemf_valid <= 1'b1;
    pwm_mode <= 1'b1;
    drv(16'h0000, 16'h0064, 8'h7F, 16'h0030, 4'h0);
    chk("loops", {freq_locked, bemf_fault, pwm_full_brake}, 34'h7);
    drv(16'h0000, 16'h0064, 8'h80, 16'h0031, 4'h1);
    chk("loops", {freq_locked, bemf_fault, pwm_full_brake}, 34'h0);
    wr(hdc_pkg::IDX_LOOP_CFG, 8'h03, 2'h0);
    wr(hdc_pkg::IDX_MEMBRK_CFG, 8'h00, 2'h0);
    drv(16'h0000, 16'h0064, 8'h00, 16'h01F2, 4'h0);
    chk("loops", {freq_locked, bemf_fault, pwm_full_brake}, 34'h2);
    wr(hdc_pkg::IDX_MEMBRK_CFG, 8'h0F, 2'h0);
    drv(16'h0000, 16'h0064, 8'h00, 16'h01F3, 4'hE);
    chk("loops", {freq_locked, bemf_fault, pwm_full_brake}, 34'h1);
    wr(hdc_pkg::IDX_LOOP_CFG, 8'h02, 2'h0);
    drv(16'h0000, 16'h0064, 8'h00, 16'h0116, 4'hF);
    chk("loops", {freq_locked, bemf_fault, pwm_full_brake}, 34'h2);
    wr(hdc_pkg::IDX_LOOP_CFG, 8'h00, 2'h0);
    drv(16'h0000, 16'h0064, 8'h00, 16'h0000, 4'hF);
    chk("loops", {freq_locked, bemf_fault, pwm_full_brake}, 34'h0);
    $display("test loop_limits done");
    close_out();
  end
endmodule
